// [verification/rxpff_monitor.sv]
// port-level assertion checker for the receive pause frame filter
`timescale 1ns/1ns
`default_nettype none

module rxpff_monitor
  import rxpff_pkg::*;
(
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // register port
  input wire logic [ADDR_W-1:0]    reg_addr,
  input wire logic [DATA_W-1:0]    reg_wr_data,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [DATA_W-1:0]    reg_rd_data,
  // receive stream in and out
  input wire logic                 rx_in_valid,
  input wire logic                 rx_in_sop,
  input wire logic                 rx_in_eop,
  input wire logic [7:0]           rx_in_data,
  input wire logic                 rx_out_valid,
  input wire logic                 rx_out_sop,
  input wire logic                 rx_out_eop,
  input wire logic [7:0]           rx_out_data,
  // notification
  input wire logic                 tx_pause_req,
  input wire logic [NUM_CLASS-1:0] tx_pause_class,
  input wire logic [15:0]          tx_pause_time
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // header bytes seen 1..6 edges back when the notification is sampled
  property p_out_from_in;
    rx_out_valid |-> $past(rx_in_valid, 17) && rx_out_data == $past(rx_in_data, 17)
      && rx_out_sop == $past(rx_in_sop, 17);
  endproperty
  a_out_from_in: assert property (p_out_from_in) else $error("client beat not from input");
  property p_req_pulse; tx_pause_req |=> !tx_pause_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("notification too long");
  property p_req_nonzero; tx_pause_req |-> tx_pause_class != '0; endproperty
  a_req_nonzero: assert property (p_req_nonzero) else $error("notification with no class");
  property p_class_hold;
    !tx_pause_req |-> $stable(tx_pause_class) && $stable(tx_pause_time);
  endproperty
  a_class_hold: assert property (p_class_hold) else $error("class changed without request");
  property p_req_timing;
    tx_pause_req |-> $past(rx_in_sop, 18) && $past(rx_in_valid, 1);
  endproperty
  a_req_timing: assert property (p_req_timing) else $error("notification at wrong cycle");
  property p_req_type;
    tx_pause_req |-> $past(rx_in_data, 6) == 8'h88 && $past(rx_in_data, 5) == 8'h08;
  endproperty
  a_req_type: assert property (p_req_type) else $error("notification for non-control frame");
  property p_std;
    tx_pause_req && $past(rx_in_data, 4) == 8'h00 |-> tx_pause_class[7:1] == '0
      && tx_pause_time == {$past(rx_in_data, 2), $past(rx_in_data, 1)};
  endproperty
  a_std: assert property (p_std) else $error("standard notification wrong");
  property p_pfc;
    tx_pause_req && $past(rx_in_data, 4) == 8'h01
      |-> (tx_pause_class & ~$past(rx_in_data, 1)) == '0 && tx_pause_time == '0;
  endproperty
  a_pfc: assert property (p_pfc) else $error("priority class not indicated");
  property p_rd_idle; reg_rd_data != '0 |-> $past(reg_rd); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule // rxpff_monitor

bind rxpff_filter rxpff_monitor u_mon (.*);

`default_nettype wire

// [verification/rxpff_partner.sv]
// far-side model: receive client sink and transmit mac queue halting
`timescale 1ns/1ns
`default_nettype none

module rxpff_partner
  import rxpff_pkg::*;
(
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // client stream
  input wire logic                 rx_out_valid,
  input wire logic                 rx_out_sop,
  input wire logic                 rx_out_eop,
  // notification
  input wire logic                 tx_pause_req,
  input wire logic [NUM_CLASS-1:0] tx_pause_class,
  // observations
  output logic [15:0]              frames_seen,
  output logic [15:0]              pauses_seen,
  output logic [15:0]              bytes_seen,
  output logic [NUM_CLASS-1:0]     halted_class
);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frames_seen  <= '0;
      pauses_seen  <= '0;
      bytes_seen   <= '0;
      halted_class <= '0;
    end else begin
      if (rx_out_valid) begin
        bytes_seen <= rx_out_sop ? 16'h1 : bytes_seen + 16'h1;
      end
      if (rx_out_valid && rx_out_eop) begin
        frames_seen <= frames_seen + 16'h1;
      end
      // only the indicated queues stop; others keep sending
      if (tx_pause_req) begin
        pauses_seen  <= pauses_seen + 16'h1;
        halted_class <= tx_pause_class;
      end
    end
  end
endmodule // rxpff_partner

`default_nettype wire

// [verification/rxpff_tb.sv]
// self-checking testbench for the receive pause frame filter
`timescale 1ns/1ns
`default_nettype none

module testbench
  import rxpff_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [ADDR_W-1:0]    reg_addr = '0;
  logic [DATA_W-1:0]    reg_wr_data = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [DATA_W-1:0]    reg_rd_data;
  logic                 rx_in_valid = 1'b0;
  logic                 rx_in_sop = 1'b0;
  logic                 rx_in_eop = 1'b0;
  logic [7:0]           rx_in_data = 8'h00;
  logic                 rx_out_valid, rx_out_sop, rx_out_eop, tx_pause_req;
  logic [7:0]           rx_out_data;
  logic [NUM_CLASS-1:0] tx_pause_class, halted_class;
  logic [15:0]          tx_pause_time, frames_seen, pauses_seen, bytes_seen;
  logic [31:0]          rv [12];
  int                   n_errors = 0;
  int                   checks = 0;
  int                   cycles = 0;

  // identification values are arbitrary
  rxpff_filter #(.REVISION_ID(32'h00000a5a), .IDENT_WORD0(32'h11223344),
                 .IDENT_WORD1(32'h55667788), .IDENT_WORD2(32'h99aabbcc)) DUT (.*);
  rxpff_partner u_far (.*);

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_val(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_check(logic [11:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check_val($sformatf("reg %h", a), exp, reg_rd_data);
  endtask

  // 20-byte frame, bytes contiguous; latency of 17/18 cycles is fixed
  task automatic frame_case(logic [47:0] da, logic [15:0] ety, logic [15:0] op,
                            logic [15:0] prm, int fwd, int req, logic [7:0] cls,
                            logic [15:0] tm);
    logic [159:0] f;
    logic [15:0]  f0, p0;
    f = {da, 48'h0a0b0c0d0e0f, ety, op, prm, 16'h5a5a};
    f0 = frames_seen;
    p0 = pauses_seen;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      rx_in_valid <= 1'b1;
      rx_in_sop <= (i == 0);
      rx_in_eop <= (i == 19);
      rx_in_data <= f[159-8*i -: 8];
    end
    @(posedge core_clk);
    rx_in_valid <= 1'b0;
    rx_in_sop <= 1'b0;
    rx_in_eop <= 1'b0;
    rx_in_data <= ~rx_in_data;
    repeat (24) @(posedge core_clk);
    check_val("frames", 32'(fwd), {16'h0, 16'(frames_seen - f0)});
    check_val("pauses", 32'(req), {16'h0, 16'(pauses_seen - p0)});
    if (fwd != 0)
      check_val("length", 32'd20, {16'h0, bytes_seen});
    if (req != 0) begin
      check_val("class", {24'h0, cls}, {24'h0, halted_class});
      check_val("time", {16'h0, tm}, {16'h0, tx_pause_time});
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rv = '{32'h0a5a, 32'h0, 32'h11223344, 32'h55667788, 32'h99aabbcc, 32'hff,
           32'h0, 32'hc2000001, 32'h0180, 32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) reg_check(12'h700 + 12'(i), rv[i]);
    // all-ones everywhere: read-only places keep, narrow ones clip
    for (int i = 0; i < 12; i++) reg_write(12'h700 + 12'(i), 32'hffffffff);
    rv[1] = 32'hffffffff;
    rv[6] = 32'h1;
    rv[7] = 32'hffffffff;
    rv[8] = 32'hffff;
    rv[9] = 32'h3;
    for (int i = 0; i < 12; i++) reg_check(12'h700 + 12'(i), rv[i]);
    // priority mode, broadcast match then 0180c2000001, forwarding on then off
    frame_case('1, 16'h8808, 16'h0101, 16'h0033, 1, 1, 8'h33, 16'h0);
    reg_write(ADDR_CLASS_EN, 32'hf0);
    frame_case('1, 16'h8808, 16'h0101, 16'h0033, 1, 1, 8'h30, 16'h0);
    reg_write(ADDR_CLASS_EN, 32'h00);
    frame_case('1, 16'h8808, 16'h0101, 16'h0033, 1, 0, 8'h0, 16'h0);
    reg_write(ADDR_CLASS_EN, 32'hff);
    reg_write(ADDR_FWD_CTRL, 32'h0);
    frame_case('1, 16'h8808, 16'h0101, 16'h0033, 0, 1, 8'h33, 16'h0);
    reg_write(ADDR_MATCH_LOW, 32'hc2000001);
    reg_write(ADDR_MATCH_HIGH, 32'h0180);
    frame_case(48'h0180c2000000, 16'h8808, 16'h0101, 16'h33, 1, 0, 8'h0, 16'h0);
    frame_case(48'h0180c2000001, 16'h0800, 16'h0101, 16'h33, 1, 0, 8'h0, 16'h0);
    // standard mode with and without the response enable
    reg_write(ADDR_FC_CTRL, 32'h1);
    frame_case(48'h0180c2000001, 16'h8808, 16'h0001, 16'h1234, 0, 1, 8'h1, 16'h1234);
    reg_write(ADDR_FC_CTRL, 32'h0);
    frame_case(48'h0180c2000001, 16'h8808, 16'h0001, 16'h1234, 0, 0, 8'h0, 16'h0);
    reg_write(ADDR_FC_CTRL, 32'h1);
    reg_write(ADDR_CLASS_EN, 32'hfe);
    frame_case(48'h0180c2000001, 16'h8808, 16'h0001, 16'h1234, 0, 0, 8'h0, 16'h0);
    reg_check(ADDR_ACT_COUNT, 32'h4);
    finish_test();
  end
endmodule // testbench

`default_nettype wire

// [verilog/rxpff_delay.sv]
// fixed-latency delay line for the receive byte stream
`timescale 1ns/1ns
`default_nettype none

module rxpff_delay
  import rxpff_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // stream in
  input  wire logic       in_valid,
  input  wire logic       in_sop,
  input  wire logic       in_eop,
  input  wire logic [7:0] in_data,
  // stream out, DELAY_DEPTH cycles later
  output logic            out_valid,
  output logic            out_sop,
  output logic            out_eop,
  output logic [7:0]      out_data
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  // each stage holds {valid, sop, eop, data}
  logic [10:0] stage_reg  [DELAY_DEPTH];
  logic [10:0] stage_next [DELAY_DEPTH];

  genvar g;
  generate
    for (g = 0; g < DELAY_DEPTH; g++) begin : g_stage
      if (g == 0) begin : g_first
        always_comb begin
          stage_next[g] = {in_valid, in_sop & in_valid, in_eop & in_valid, in_data};
        end
      end else begin : g_rest
        always_comb begin
          stage_next[g] = stage_reg[g-1];
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stage_reg[g] <= 11'h000;
        end else begin
          stage_reg[g] <= stage_next[g];
        end
      end
    end
  endgenerate

  assign out_valid = stage_reg[DELAY_DEPTH-1][10];
  assign out_sop   = stage_reg[DELAY_DEPTH-1][9];
  assign out_eop   = stage_reg[DELAY_DEPTH-1][8];
  assign out_data  = stage_reg[DELAY_DEPTH-1][7:0];

endmodule // rxpff_delay

`default_nettype wire

// [verilog/rxpff_filter.sv]
// receive pause frame filter: parser, match, notification, client gating, registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module rxpff_filter
  import rxpff_pkg::*;
#(
  // identification values are arbitrary
  parameter logic [31:0] REVISION_ID = 32'h00010000,
  parameter logic [31:0] IDENT_WORD0 = 32'h61626364,
  parameter logic [31:0] IDENT_WORD1 = 32'h65666768,
  parameter logic [31:0] IDENT_WORD2 = 32'h696a6b6c
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wr_data,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rd_data,
  // receive stream from the mac
  input  wire logic              rx_in_valid,
  input  wire logic              rx_in_sop,
  input  wire logic              rx_in_eop,
  input  wire logic [7:0]        rx_in_data,
  // receive stream to the client
  output logic                   rx_out_valid,
  output logic                   rx_out_sop,
  output logic                   rx_out_eop,
  output logic [7:0]             rx_out_data,
  // notification to the transmit mac
  output logic                   tx_pause_req,
  output logic [NUM_CLASS-1:0]   tx_pause_class,
  output logic [15:0]            tx_pause_time
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]          scratch_reg, scratch_next;
  logic [NUM_CLASS-1:0] class_en_reg, class_en_next;
  logic                 fwd_reg, fwd_next;
  logic [31:0]          match_low_reg, match_low_next;
  logic [15:0]          match_high_reg, match_high_next;
  logic [1:0]           fc_ctrl_reg, fc_ctrl_next;
  logic [15:0]          act_count_reg, act_count_next;
  logic [31:0]          rd_data_reg, rd_data_next;

  // ----------------------------------------------------------------
  // parser state
  // ----------------------------------------------------------------
  logic [4:0]           idx_reg, idx_next;
  logic [47:0]          da_reg, da_next;
  logic [7:0]           prev_reg, prev_next;
  logic                 type_ok_reg, type_ok_next;
  logic                 acted_reg, acted_next;
  logic                 dec_valid_reg, dec_valid_next;
  logic                 dec_hold_reg, dec_hold_next;
  logic                 req_reg, req_next;
  logic [NUM_CLASS-1:0] class_reg, class_next;
  logic [15:0]          time_reg, time_next;

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic                 drop_frame_reg, drop_frame_next;
  logic                 out_valid_reg, out_valid_next;
  logic                 out_sop_reg, out_sop_next;
  logic                 out_eop_reg, out_eop_next;
  logic [7:0]           out_data_reg, out_data_next;

  logic                 d_valid;
  logic                 d_sop;
  logic                 d_eop;
  logic [7:0]           d_data;

  rxpff_delay u_delay (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rx_in_valid),
    .in_sop    (rx_in_sop),
    .in_eop    (rx_in_eop),
    .in_data   (rx_in_data),
    .out_valid (d_valid),
    .out_sop   (d_sop),
    .out_eop   (d_eop),
    .out_data  (d_data)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    scratch_next    = scratch_reg;
    class_en_next   = class_en_reg;
    fwd_next        = fwd_reg;
    match_low_next  = match_low_reg;
    match_high_next = match_high_reg;
    fc_ctrl_next    = fc_ctrl_reg;
    rd_data_next    = 32'h00000000;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SCRATCH:    scratch_next    = reg_wr_data;
        ADDR_CLASS_EN:   class_en_next   = reg_wr_data[NUM_CLASS-1:0];
        ADDR_FWD_CTRL:   fwd_next        = reg_wr_data[0];
        ADDR_MATCH_LOW:  match_low_next  = reg_wr_data;
        ADDR_MATCH_HIGH: match_high_next = reg_wr_data[15:0];
        ADDR_FC_CTRL:    fc_ctrl_next    = reg_wr_data[1:0];
        // revision and identifier words ignore writes
        default:         scratch_next    = scratch_reg;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_REVISION:   rd_data_next = REVISION_ID;
        ADDR_SCRATCH:    rd_data_next = scratch_reg;
        ADDR_IDENT0:     rd_data_next = IDENT_WORD0;
        ADDR_IDENT1:     rd_data_next = IDENT_WORD1;
        ADDR_IDENT2:     rd_data_next = IDENT_WORD2;
        ADDR_CLASS_EN:   rd_data_next = {24'h000000, class_en_reg};
        ADDR_FWD_CTRL:   rd_data_next = {31'h00000000, fwd_reg};
        ADDR_MATCH_LOW:  rd_data_next = match_low_reg;
        ADDR_MATCH_HIGH: rd_data_next = {16'h0000, match_high_reg};
        ADDR_FC_CTRL:    rd_data_next = {30'h00000000, fc_ctrl_reg};
        ADDR_ACT_COUNT:  rd_data_next = {16'h0000, act_count_reg};
        default:         rd_data_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scratch_reg    <= SCRATCH_RESET;
      class_en_reg   <= CLASS_EN_RESET;
      fwd_reg        <= FWD_RESET;
      match_low_reg  <= MATCH_LOW_RESET;
      match_high_reg <= MATCH_HIGH_RESET;
      fc_ctrl_reg    <= FC_CTRL_RESET;
      rd_data_reg    <= 32'h00000000;
    end else begin
      scratch_reg    <= scratch_next;
      class_en_reg   <= class_en_next;
      fwd_reg        <= fwd_next;
      match_low_reg  <= match_low_next;
      match_high_reg <= match_high_next;
      fc_ctrl_reg    <= fc_ctrl_next;
      rd_data_reg    <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // header parser and pause decision
  // ----------------------------------------------------------------
  // bytes must arrive back to back within a frame: the verdict is timed
  // against the fixed delay line, a gap in the header would misalign it
  logic [4:0]           idx_cur;
  logic [15:0]          pair;
  logic                 pfc_mode;
  logic                 is_pause;
  logic                 addr_match;
  logic [NUM_CLASS-1:0] hit_class;

  always_comb begin
    idx_cur        = rx_in_sop ? 5'h00 : idx_reg;
    pair           = {prev_reg, rx_in_data};
    pfc_mode       = fc_ctrl_reg[FC_PFC_MODE_BIT];
    is_pause       = type_ok_reg && (pair == (pfc_mode ? OPCODE_PFC : OPCODE_STD));
    addr_match     = (da_reg == {match_high_reg, match_low_reg});
    hit_class      = '0;
    if (pfc_mode) begin
      hit_class = pair[NUM_CLASS-1:0] & class_en_reg;
    end else begin
      // standard mode has one queue, only bit 0 counts
      hit_class[0] = class_en_reg[0] & fc_ctrl_reg[FC_RESP_EN_BIT];
    end
    idx_next       = idx_reg;
    da_next        = da_reg;
    prev_next      = prev_reg;
    type_ok_next   = type_ok_reg;
    acted_next     = acted_reg;
    dec_valid_next = 1'b0;
    dec_hold_next  = dec_hold_reg;
    req_next       = 1'b0;
    class_next     = class_reg;
    time_next      = time_reg;
    act_count_next = act_count_reg;
    if (rx_in_valid) begin
      prev_next = rx_in_data;
      idx_next  = (idx_cur == IDX_MAX) ? IDX_MAX : idx_cur + 5'h01;
      if (idx_cur < IDX_DA_END) begin
        da_next = {da_reg[39:0], rx_in_data};
      end
      if (rx_in_sop) begin
        type_ok_next = 1'b0;
        acted_next   = 1'b0;
      end
      if (idx_cur == IDX_TYPE_LAST) begin
        type_ok_next = (pair == ETYPE_MAC_CTRL);
      end
      if (idx_cur == IDX_OP_LAST) begin
        // matched pause frames are withheld unless forwarding is on
        dec_valid_next = 1'b1;
        dec_hold_next  = is_pause && addr_match && !fwd_reg;
        acted_next     = is_pause && addr_match;
      end
      if ((idx_cur == IDX_PARAM) && acted_reg && (hit_class != '0)) begin
        req_next       = 1'b1;
        class_next     = hit_class;
        time_next      = pfc_mode ? 16'h0000 : pair;
        act_count_next = act_count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      idx_reg       <= 5'h00;
      da_reg        <= 48'h000000000000;
      prev_reg      <= 8'h00;
      type_ok_reg   <= 1'b0;
      acted_reg     <= 1'b0;
      dec_valid_reg <= 1'b0;
      dec_hold_reg  <= 1'b0;
      req_reg       <= 1'b0;
      class_reg     <= '0;
      time_reg      <= 16'h0000;
      act_count_reg <= 16'h0000;
    end else begin
      idx_reg       <= idx_next;
      da_reg        <= da_next;
      prev_reg      <= prev_next;
      type_ok_reg   <= type_ok_next;
      acted_reg     <= acted_next;
      dec_valid_reg <= dec_valid_next;
      dec_hold_reg  <= dec_hold_next;
      req_reg       <= req_next;
      class_reg     <= class_next;
      time_reg      <= time_next;
      act_count_reg <= act_count_next;
    end
  end

  // ----------------------------------------------------------------
  // client gating
  // ----------------------------------------------------------------
  // the verdict pulse lines up with the frame's first byte leaving the
  // delay line; frames too short to reach it always pass
  logic drop_cur;

  always_comb begin
    drop_cur        = d_sop ? (dec_valid_reg & dec_hold_reg) : drop_frame_reg;
    drop_frame_next = (d_valid && d_eop) ? 1'b0 : drop_cur;
    out_valid_next  = d_valid & ~drop_cur;
    out_sop_next    = d_sop & ~drop_cur;
    out_eop_next    = d_eop & ~drop_cur;
    out_data_next   = d_data;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drop_frame_reg <= 1'b0;
      out_valid_reg  <= 1'b0;
      out_sop_reg    <= 1'b0;
      out_eop_reg    <= 1'b0;
      out_data_reg   <= 8'h00;
    end else begin
      drop_frame_reg <= drop_frame_next;
      out_valid_reg  <= out_valid_next;
      out_sop_reg    <= out_sop_next;
      out_eop_reg    <= out_eop_next;
      out_data_reg   <= out_data_next;
    end
  end

  assign reg_rd_data    = rd_data_reg;
  assign rx_out_valid   = out_valid_reg;
  assign rx_out_sop     = out_sop_reg;
  assign rx_out_eop     = out_eop_reg;
  assign rx_out_data    = out_data_reg;
  assign tx_pause_req   = req_reg;
  assign tx_pause_class = class_reg;
  assign tx_pause_time  = time_reg;

endmodule // rxpff_filter

`default_nettype wire

// [verilog/rxpff_pkg.sv]
// constants, register map and frame layout for the receive pause frame filter
package rxpff_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] ADDR_REVISION   = 12'h700;
  localparam logic [11:0] ADDR_SCRATCH    = 12'h701;
  localparam logic [11:0] ADDR_IDENT0     = 12'h702;
  localparam logic [11:0] ADDR_IDENT1     = 12'h703;
  localparam logic [11:0] ADDR_IDENT2     = 12'h704;
  localparam logic [11:0] ADDR_CLASS_EN   = 12'h705;
  localparam logic [11:0] ADDR_FWD_CTRL   = 12'h706;
  localparam logic [11:0] ADDR_MATCH_LOW  = 12'h707;
  localparam logic [11:0] ADDR_MATCH_HIGH = 12'h708;
  localparam logic [11:0] ADDR_FC_CTRL    = 12'h709;
  localparam logic [11:0] ADDR_ACT_COUNT  = 12'h70a;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam int          NUM_CLASS        = 8;
  localparam logic [7:0]  CLASS_EN_RESET   = 8'hff;
  localparam logic [31:0] SCRATCH_RESET    = 32'h00000000;
  localparam logic        FWD_RESET        = 1'h0;
  localparam logic [31:0] MATCH_LOW_RESET  = 32'hc2000001;
  localparam logic [15:0] MATCH_HIGH_RESET = 16'h0180;
  localparam logic [1:0]  FC_CTRL_RESET    = 2'h0;
  localparam int          FC_RESP_EN_BIT   = 0;
  localparam int          FC_PFC_MODE_BIT  = 1;

  // ----------------------------------------------------------------
  // frame layout, byte indices from the first destination byte
  // ----------------------------------------------------------------
  localparam logic [4:0]  IDX_DA_END    = 5'h06;
  localparam logic [4:0]  IDX_TYPE_LAST = 5'h0d;
  localparam logic [4:0]  IDX_OP_LAST   = 5'h0f;
  localparam logic [4:0]  IDX_PARAM     = 5'h11;
  localparam logic [4:0]  IDX_MAX       = 5'h1f;
  localparam logic [15:0] ETYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] OPCODE_STD    = 16'h0001;
  localparam logic [15:0] OPCODE_PFC    = 16'h0101;

  // stream delay: one stage more than the last header byte needed for the verdict
  localparam int          DELAY_DEPTH   = 16;

endpackage : rxpff_pkg
